/* shared/cmp_map.svh */
`ifndef CMP_MAP_SVH
`define CMP_MAP_SVH

// ----------------------------------------
// Register indices, byte address = 4 * index
// ----------------------------------------
`define CMP_CTRL0_IDX 8'h9A
`define CMP_MODE0_IDX 8'h9B
`define CMP_CTRL1_IDX 8'h9D
`define CMP_MODE1_IDX 8'h9E
`define CMP_INSEL0_IDX 8'hA0
`define CMP_INSEL1_IDX 8'hA1
`define CMP_STAT_IDX 8'hA2
`define CMP_MASK_IDX 8'hA3

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CMP_ON_BIT 7
`define CMP_RESULT_BIT 6
`define CMP_RISE_BIT 5
`define CMP_FALL_BIT 4
`define CMP_HYSP_HI 3
`define CMP_HYSP_LO 2
`define CMP_HYSN_HI 1
`define CMP_HYSN_LO 0

// ----------------------------------------
// Mode and input select fields
// ----------------------------------------
`define CMP_RIE_BIT 5
`define CMP_FIE_BIT 4
`define CMP_MODE_HI 1
`define CMP_MODE_LO 0
`define CMP_PSEL_HI 1
`define CMP_PSEL_LO 0
`define CMP_NSEL_HI 5
`define CMP_NSEL_LO 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMP_MODE_RST 2'h2
`define CMP_FIELD_RST 2'h0

`endif

/* shared/cmp_pkg.sv */
package cmp_pkg;

    typedef enum logic [1:0] {
        CMP_MODE_FAST = 2'b00,
        CMP_MODE_ONE = 2'b01,
        CMP_MODE_TWO = 2'b10,
        CMP_MODE_SLOW = 2'b11
    } cmp_mode_t;

    // Settings that leave the block for the analog side
    typedef struct packed {
        logic on;
        logic [1:0] hysP;
        logic [1:0] hysN;
        cmp_mode_t mode;
        logic [1:0] posSel;
        logic [1:0] negSel;
    } cmp_cfg_t;

    // Full software state of one comparator
    typedef struct packed {
        cmp_cfg_t cfg;
        logic riseIe;
        logic fallIe;
        logic riseFlag;
        logic fallFlag;
    } cmp_regs_t;

endpackage

/* src/cmp_ctrl_top.sv */
`include "cmp_map.svh"

module cmp_ctrl_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog side
    input wire logic [1:0] rawCompare,
    output cmp_pkg::cmp_cfg_t [1:0] cmpCfg,
    // Pin outputs
    output logic [1:0] latchedCompareOut,
    output logic [1:0] rawCompareOut,
    // Interrupt
    output logic irq
);

    // ----------------------------------------
    // Address decode helpers
    // ----------------------------------------
    function automatic logic [11:0] regAddr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    function automatic logic isMapped(input logic [11:0] a);
        return a == regAddr(`CMP_CTRL0_IDX) || a == regAddr(`CMP_MODE0_IDX)
            || a == regAddr(`CMP_CTRL1_IDX) || a == regAddr(`CMP_MODE1_IDX)
            || a == regAddr(`CMP_INSEL0_IDX) || a == regAddr(`CMP_INSEL1_IDX)
            || a == regAddr(`CMP_STAT_IDX) || a == regAddr(`CMP_MASK_IDX);
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rstPipe;
    logic nrstSync;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end

    assign nrstSync = rstPipe[1];

    // ----------------------------------------
    // State
    // ----------------------------------------
    cmp_pkg::cmp_regs_t regs [2];
    cmp_pkg::cmp_regs_t next_regs [2];
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [1:0] lat;
    logic [1:0] prev;
    logic [1:0] next_lat;
    logic [31:0] next_prdata;
    logic errReg;
    logic next_err;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [3:0] statVec;
    logic [3:0] maskVec;
    logic wrAcc;
    logic rdSetup;

    assign wrAcc = psel && penable && pwrite;
    assign rdSetup = psel && !penable;

    // Edges on the gated, synchronised copy only
    assign rise = lat & ~prev;
    assign fall = ~lat & prev;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            statVec[2 * i] = regs[i].fallFlag;
            statVec[2 * i + 1] = regs[i].riseFlag;
            maskVec[2 * i] = regs[i].fallIe;
            maskVec[2 * i + 1] = regs[i].riseIe;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [7:0] ctrlIdx;
        logic [7:0] modeIdx;
        logic [7:0] selIdx;
        ctrlIdx = `CMP_CTRL0_IDX;
        modeIdx = `CMP_MODE0_IDX;
        selIdx = `CMP_INSEL0_IDX;
        next_regs = regs;
        next_lat = syncB & {regs[1].cfg.on, regs[0].cfg.on};
        next_prdata = 32'h0000_0000;
        next_err = rdSetup && !isMapped(paddr);
        for (int i = 0; i < 2; i++) begin
            ctrlIdx = (i == 0) ? `CMP_CTRL0_IDX : `CMP_CTRL1_IDX;
            modeIdx = (i == 0) ? `CMP_MODE0_IDX : `CMP_MODE1_IDX;
            selIdx = (i == 0) ? `CMP_INSEL0_IDX : `CMP_INSEL1_IDX;
            if (wrAcc && paddr == regAddr(ctrlIdx)) begin
                next_regs[i].cfg.on = pwdata[`CMP_ON_BIT];
                next_regs[i].riseFlag = pwdata[`CMP_RISE_BIT];
                next_regs[i].fallFlag = pwdata[`CMP_FALL_BIT];
                next_regs[i].cfg.hysP = pwdata[`CMP_HYSP_HI:`CMP_HYSP_LO];
                next_regs[i].cfg.hysN = pwdata[`CMP_HYSN_HI:`CMP_HYSN_LO];
            end else if (wrAcc && paddr == regAddr(modeIdx)) begin
                next_regs[i].riseIe = pwdata[`CMP_RIE_BIT];
                next_regs[i].fallIe = pwdata[`CMP_FIE_BIT];
                next_regs[i].cfg.mode =
                    cmp_pkg::cmp_mode_t'(pwdata[`CMP_MODE_HI:`CMP_MODE_LO]);
            end else if (wrAcc && paddr == regAddr(selIdx)) begin
                next_regs[i].cfg.posSel = pwdata[`CMP_PSEL_HI:`CMP_PSEL_LO];
                next_regs[i].cfg.negSel = pwdata[`CMP_NSEL_HI:`CMP_NSEL_LO];
            end else if (wrAcc && paddr == regAddr(`CMP_STAT_IDX)) begin
                // Status view clears by writing ones
                if (pwdata[2 * i + 1]) begin
                    next_regs[i].riseFlag = 1'b0;
                end
                if (pwdata[2 * i]) begin
                    next_regs[i].fallFlag = 1'b0;
                end
            end else if (wrAcc && paddr == regAddr(`CMP_MASK_IDX)) begin
                next_regs[i].riseIe = pwdata[2 * i + 1];
                next_regs[i].fallIe = pwdata[2 * i];
            end
            // Hardware set wins over a clear in the same cycle
            if (rise[i]) begin
                next_regs[i].riseFlag = 1'b1;
            end
            if (fall[i]) begin
                next_regs[i].fallFlag = 1'b1;
            end
            if (rdSetup && paddr == regAddr(ctrlIdx)) begin
                next_prdata[7:0] = {regs[i].cfg.on, lat[i],
                    regs[i].riseFlag, regs[i].fallFlag,
                    regs[i].cfg.hysP, regs[i].cfg.hysN};
            end else if (rdSetup && paddr == regAddr(modeIdx)) begin
                next_prdata[7:0] = {2'b00, regs[i].riseIe, regs[i].fallIe,
                    2'b00, regs[i].cfg.mode};
            end else if (rdSetup && paddr == regAddr(selIdx)) begin
                next_prdata[7:0] = {2'b00, regs[i].cfg.negSel,
                    2'b00, regs[i].cfg.posSel};
            end
        end
        if (rdSetup && paddr == regAddr(`CMP_STAT_IDX)) begin
            next_prdata[3:0] = statVec;
        end else if (rdSetup && paddr == regAddr(`CMP_MASK_IDX)) begin
            next_prdata[3:0] = maskVec;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrstSync) begin
        if (!nrstSync) begin
            for (int i = 0; i < 2; i++) begin
                regs[i].cfg.on <= 1'b0;
                regs[i].cfg.hysP <= `CMP_FIELD_RST;
                regs[i].cfg.hysN <= `CMP_FIELD_RST;
                regs[i].cfg.mode <= cmp_pkg::cmp_mode_t'(`CMP_MODE_RST);
                regs[i].cfg.posSel <= `CMP_FIELD_RST;
                regs[i].cfg.negSel <= `CMP_FIELD_RST;
                regs[i].riseIe <= 1'b0;
                regs[i].fallIe <= 1'b0;
                regs[i].riseFlag <= 1'b0;
                regs[i].fallFlag <= 1'b0;
            end
            syncA <= 2'b00;
            syncB <= 2'b00;
            lat <= 2'b00;
            prev <= 2'b00;
            prdata <= 32'h0000_0000;
            errReg <= 1'b0;
        end else begin
            regs <= next_regs;
            syncA <= rawCompare;
            syncB <= syncA;
            lat <= next_lat;
            prev <= lat;
            prdata <= next_prdata;
            errReg <= next_err;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Zero wait states: read data is staged in the setup cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && errReg;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cmpCfg[i] = regs[i].cfg;
        end
    end

    // No clock on this path, so it still works in stop mode
    assign rawCompareOut = rawCompare & {regs[1].cfg.on, regs[0].cfg.on};
    assign latchedCompareOut = lat;
    assign irq = |(statVec & maskVec);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrstSync);

    property p_rawOff;
        !regs[0].cfg.on |-> !rawCompareOut[0];
    endproperty
    a_rawOff: assert property (p_rawOff) else $error("raw out high while off");

    property p_latOff;
        !regs[1].cfg.on ##1 !regs[1].cfg.on |-> !latchedCompareOut[1];
    endproperty
    a_latOff: assert property (p_latOff) else $error("latched out high while off");

    property p_riseSet;
        regs[0].cfg.on && $rose(lat[0]) |=> regs[0].riseFlag;
    endproperty
    a_riseSet: assert property (p_riseSet) else $error("rise flag not set");

    property p_fallSet;
        $fell(lat[1]) |=> regs[1].fallFlag;
    endproperty
    a_fallSet: assert property (p_fallSet) else $error("fall flag not set");

    property p_sticky;
        regs[0].riseFlag && !(wrAcc && (paddr == regAddr(`CMP_CTRL0_IDX)
            || paddr == regAddr(`CMP_STAT_IDX))) |=> regs[0].riseFlag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("rise flag lost");

    property p_irq;
        regs[1].fallFlag && regs[1].fallIe |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_noIrq;
        !regs[0].riseIe && !regs[0].fallIe && !regs[1].riseIe && !regs[1].fallIe |-> !irq;
    endproperty
    a_noIrq: assert property (p_noIrq) else $error("spurious interrupt");

    property p_readOut;
        rdSetup && paddr == regAddr(`CMP_CTRL0_IDX)
            |=> prdata[`CMP_RESULT_BIT] == $past(lat[0]);
    endproperty
    a_readOut: assert property (p_readOut) else $error("result bit wrong");

    property p_enable;
        wrAcc && paddr == regAddr(`CMP_CTRL1_IDX)
            |=> regs[1].cfg.on == $past(pwdata[`CMP_ON_BIT]);
    endproperty
    a_enable: assert property (p_enable) else $error("enable not taken");

    property p_hys;
        wrAcc && paddr == regAddr(`CMP_CTRL0_IDX)
            |=> cmpCfg[0].hysP == $past(pwdata[3:2]) && cmpCfg[0].hysN == $past(pwdata[1:0]);
    endproperty
    a_hys: assert property (p_hys) else $error("hysteresis not taken");

    property p_sync;
        regs[0].cfg.on [*4] |-> latchedCompareOut[0] == $past(rawCompare[0], 3);
    endproperty
    a_sync: assert property (p_sync) else $error("sync delay wrong");

endmodule

/* test/cmp_analog_model.sv */
module cmp_analog_model (
    // Settings from the block
    input wire cmp_pkg::cmp_cfg_t [1:0] cfg,
    // Pin levels, four selectable pins per comparator
    input wire logic [1:0][3:0] pinHigh,
    // Comparison results
    output logic [1:0] rawCompare
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] above;

    // ----------------------------------------
    // Comparison through the selected pins
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            above[i] = pinHigh[i][cfg[i].posSel] & ~pinHigh[i][cfg[i].negSel];
            // Powered down: result is meaningless, so never echo a stale value
            rawCompare[i] = cfg[i].on ? above[i] : ~above[i];
        end
    end
endmodule

/* test/cmp_ctrl_top_tb.sv */
`include "cmp_map.svh"

module cmp_ctrl_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, clkRun = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, irq, lastErr;
    logic [1:0] rawCompare, latchedCompareOut, rawCompareOut;
    logic [1:0][3:0] pinHigh = '0;
    cmp_pkg::cmp_cfg_t [1:0] cmpCfg;
    int n_fail = 0, num_checks = 0;

    cmp_ctrl_top i_cmp_ctrl_top (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rawCompare(rawCompare),
        .cmpCfg(cmpCfg), .latchedCompareOut(latchedCompareOut),
        .rawCompareOut(rawCompareOut), .irq(irq));
    cmp_analog_model i_cmp_analog_model (.cfg(cmpCfg), .pinHigh(pinHigh),
        .rawCompare(rawCompare));

    // ----------------------------------------
    // Clock, gated to show the unclocked path
    // ----------------------------------------
    initial begin
        forever begin
            #25;
            if (clkRun) ref_clk = ~ref_clk;
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string msg);
        apb(1'b0, idx, '0);
        check(rd, exp, msg);
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rdc(`CMP_CTRL0_IDX, 32'h0000_0000, "ctrl0 reset");
        rdc(`CMP_MODE0_IDX, 32'h0000_0002, "mode0 reset");
        rdc(`CMP_CTRL1_IDX, 32'h0000_0000, "ctrl1 reset");
        rdc(`CMP_MODE1_IDX, 32'h0000_0002, "mode1 reset");
        rdc(`CMP_STAT_IDX, 32'h0000_0000, "status reset");
        check(irq, 1'b0, "irq reset");
        rdc(8'h10, 32'h0000_0000, "unmapped read");
        check(lastErr, 1'b1, "unmapped error");
    endtask

    task automatic t_fields;
        for (int k = 0; k < 4; k++) begin
            wr(`CMP_CTRL1_IDX, 32'h0000_0080 | 32'(k << 2) | 32'(k));
            // Register lands on the edge that ends the access; look one edge later
            ticks(1);
            check(cmpCfg[1].hysP, 32'(k), "hys pos");
            check(cmpCfg[1].hysN, 32'(k), "hys neg");
            check(cmpCfg[1].on, 1'b1, "on");
            wr(`CMP_MODE1_IDX, 32'h0000_00CC | 32'(k));
            ticks(1);
            check(cmpCfg[1].mode, 32'(k), "mode out");
            rdc(`CMP_MODE1_IDX, 32'(k), "mode read");
        end
        wr(`CMP_CTRL1_IDX, 32'h0000_0000);
        wr(`CMP_MODE1_IDX, 32'h0000_0002);
    endtask

    task automatic t_edges;
        wr(`CMP_INSEL0_IDX, 32'h0000_0021);
        wr(`CMP_MODE0_IDX, 32'h0000_0032);
        wr(`CMP_CTRL0_IDX, 32'h0000_0080);
        ticks(6);
        wr(`CMP_CTRL0_IDX, 32'h0000_0080);
        pinHigh[0] <= 4'b0010;
        ticks(1);
        check(rawCompareOut[0], 1'b1, "raw out");
        ticks(5);
        check(latchedCompareOut[0], 1'b1, "latched out");
        check(irq, 1'b1, "rise irq");
        rdc(`CMP_CTRL0_IDX, 32'h0000_00E0, "rise flag");
        wr(`CMP_CTRL0_IDX, 32'h0000_0080);
        rdc(`CMP_CTRL0_IDX, 32'h0000_00C0, "rise clear");
        check(irq, 1'b0, "irq cleared");
        pinHigh[0] <= 4'b0000;
        ticks(6);
        rdc(`CMP_CTRL0_IDX, 32'h0000_0090, "fall flag");
        pinHigh[0] <= 4'b0010;
        ticks(6);
        rdc(`CMP_CTRL0_IDX, 32'h0000_00F0, "sticky");
        wr(`CMP_STAT_IDX, 32'h0000_0003);
        rdc(`CMP_STAT_IDX, 32'h0000_0000, "status clear");
        wr(`CMP_INSEL0_IDX, 32'h0000_0012);
        ticks(6);
        rdc(`CMP_CTRL0_IDX, 32'h0000_0090, "input swap");
        wr(`CMP_MODE0_IDX, 32'h0000_0002);
        rdc(`CMP_MASK_IDX, 32'h0000_0000, "mask view");
        check(irq, 1'b0, "masked");
        // Clock stopped: only the raw path may react
        @(posedge ref_clk);
        clkRun = 0;
        #100 pinHigh[0] = 4'b0100;
        #10 check(rawCompareOut[0], 1'b1, "no clock high");
        pinHigh[0] = 4'b0000;
        #10 check(rawCompareOut[0], 1'b0, "no clock low");
        pinHigh[0] = 4'b0100;
        clkRun = 1;
        ticks(6);
        wr(`CMP_CTRL0_IDX, 32'h0000_0000);
        ticks(1);
        check(rawCompareOut[0], 1'b0, "raw off");
        ticks(4);
        check(latchedCompareOut[0], 1'b0, "latched off");
        check(cmpCfg[0].on, 1'b0, "powered down");
        wr(`CMP_CTRL0_IDX, 32'h0000_0000);
    endtask

    task automatic t_second;
        wr(`CMP_INSEL1_IDX, 32'h0000_0021);
        wr(`CMP_MASK_IDX, 32'h0000_0008);
        rdc(`CMP_MODE1_IDX, 32'h0000_0022, "mask to mode");
        wr(`CMP_CTRL1_IDX, 32'h0000_0080);
        ticks(6);
        wr(`CMP_STAT_IDX, 32'h0000_000F);
        pinHigh[1] <= 4'b0010;
        ticks(6);
        rdc(`CMP_STAT_IDX, 32'h0000_0008, "second rise");
        check(irq, 1'b1, "second irq");
        check(latchedCompareOut[1], 1'b1, "second latched");
        wr(`CMP_STAT_IDX, 32'h0000_0008);
        rdc(`CMP_CTRL1_IDX, 32'h0000_00C0, "second clear");
        check(irq, 1'b0, "second irq off");
    endtask

    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1;
        ticks(3);
        t_reset();
        t_fields();
        t_edges();
        t_second();
        print_verdict();
    end

    initial begin
        #100_000;
        n_fail++;
        print_verdict();
    end
endmodule
